// File: ppp_port.v
// parallel programming port, device side
// Operation
// - done indicator low while programming, else high
// - drive data bus only while output enable low
// - program pulse starts programming when an erase or write command is loaded, indicator falls
// - byte select: 0 low byte, 1 high
// - action bits select address, data, command, idle
// - address byte chosen by byte select
// - data byte chosen by byte select
// - decode erase and write commands
// - decode read commands
// - select stable 100ns after high voltage, else fail
// - command and address kept through programming
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.vh"
module ppp_port #(
    parameter PROG_CYC = `PPP_PROG_CYC,
    parameter BS_HOLD  = `PPP_BS_HOLD_CYC
) (
    // clock, reset, enable
    input  wire        clock,
    input  wire        reset_n,
    input  wire        clock_en,
    // programming entry
    input  wire        high_voltage_present,
    output reg         prog_mode,
    // control pins
    input  wire        crystal_strobe_input,
    input  wire        latch_action_lo,
    input  wire        latch_action_hi,
    input  wire        byte_half_select,
    input  wire        output_drive_n,
    input  wire        program_pulse_n,
    output reg         prog_done_indicator,
    // data bus
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output reg         data_oe,
    // memory side
    output reg         mem_write,
    output reg         mem_erase,
    output reg  [7:0]  mem_cmd,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [7:0]  mem_rdata_lo,
    input  wire [7:0]  mem_rdata_hi
);
    // sequencer states
    localparam ST_OFF   = 2'h0;
    localparam ST_ENTRY = 2'h1;
    localparam ST_READY = 2'h2;
    localparam ST_BUSY  = 2'h3;

    wire [6:0] pins_s;
    wire [7:0] data_s;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [15:0] count;
    reg  [15:0] next_count;
    reg        xtal_d;
    reg        wr_d;
    reg        hv_d;
    reg        bs_at_entry;
    reg        is_write_cmd;
    reg        is_read_cmd;
    // synchronised pin fields
    wire       xtal_s = pins_s[0];
    wire [1:0] action = pins_s[2:1];
    wire       bs_s   = pins_s[3];
    wire       oe_n_s = pins_s[4];
    wire       wr_n_s = pins_s[5];
    wire       hv_s   = pins_s[6];
    // edges of the synchronised strobes
    wire       xtal_rise  = xtal_s & ~xtal_d;
    wire       wr_fall    = ~wr_n_s & wr_d;
    wire       hv_rise    = hv_s & ~hv_d;
    // loads are only taken while ready
    wire       load_stb   = (state == ST_READY) && xtal_rise;
    wire       load_addr  = load_stb && (action == `PPP_ACT_ADDR);
    wire       load_data  = load_stb && (action == `PPP_ACT_DATA);
    wire       load_cmd   = load_stb && (action == `PPP_ACT_CMD);
    wire       start_prog = (state == ST_READY) && (next_state == ST_BUSY);
    wire       next_mode  = (next_state == ST_READY) || (next_state == ST_BUSY);

    // command classes
    always @* begin
        is_write_cmd = 1'b0;
        is_read_cmd  = 1'b0;
        case (mem_cmd)
            `PPP_CMD_ERASE,
            `PPP_CMD_WR_FUSE,
            `PPP_CMD_WR_LOCK,
            `PPP_CMD_WR_FLASH,
            `PPP_CMD_WR_EEPROM: begin
                is_write_cmd = 1'b1;
            end
            `PPP_CMD_RD_SIG,
            `PPP_CMD_RD_FUSE,
            `PPP_CMD_RD_FLASH,
            `PPP_CMD_RD_EEPROM: begin
                is_read_cmd = 1'b1;
            end
            default: begin
                is_write_cmd = 1'b0;
                is_read_cmd  = 1'b0;
            end
        endcase
    end

    ppp_sync #(.WIDTH(7)) u_pin_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .async_in ({high_voltage_present, program_pulse_n, output_drive_n, byte_half_select,
                    latch_action_hi, latch_action_lo, crystal_strobe_input}),
        .sync_out (pins_s)
    );
    ppp_sync #(.WIDTH(8)) u_data_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .async_in (data_in),
        .sync_out (data_s)
    );

    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            ST_OFF: begin
                next_count = 16'h0000;
                // only a fresh high-voltage edge may start entry
                if (hv_rise && !bs_s)
                    next_state = ST_ENTRY;
            end
            ST_ENTRY: begin
                // select must stay put while high voltage settles
                if (!hv_s)
                    next_state = ST_OFF;
                else if (bs_s != bs_at_entry)
                    next_state = ST_OFF;
                else if (count >= BS_HOLD[15:0] - 16'h0001)
                    next_state = ST_READY;
                else
                    next_count = count + 16'h0001;
            end
            ST_READY: begin
                next_count = 16'h0000;
                if (!hv_s)
                    next_state = ST_OFF;
                else if (wr_fall && is_write_cmd)
                    next_state = ST_BUSY;
            end
            ST_BUSY: begin
                if (count >= PROG_CYC[15:0] - 16'h0001)
                    next_state = hv_s ? ST_READY : ST_OFF;
                else
                    next_count = count + 16'h0001;
            end
            default: next_state = ST_OFF;
        endcase
    end

    // strobe history; reset level matches the synchroniser, so no false edge
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            xtal_d <= 1'b0;
            wr_d   <= 1'b0;
        end else if (clock_en) begin
            xtal_d <= xtal_s;
            wr_d   <= wr_n_s;
        end
    end

    // high-voltage history for the entry edge
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hv_d <= 1'b0;
        end else if (clock_en) begin
            hv_d <= hv_s;
        end
    end

    // sequencer
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_OFF;
            count <= 16'h0000;
        end else if (clock_en) begin
            state <= next_state;
            count <= next_count;
        end
    end

    // select level seen while the sequencer is off
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bs_at_entry <= 1'b0;
        end else if (clock_en) begin
            if (state == ST_OFF)
                bs_at_entry <= bs_s;
        end
    end

    // mode flag lines up with the next state
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prog_mode <= 1'b0;
        end else if (clock_en) begin
            prog_mode <= next_mode;
        end
    end

    // ready flag low for the whole programming time
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prog_done_indicator <= 1'b1;
        end else if (clock_en) begin
            prog_done_indicator <= (next_state != ST_BUSY);
        end
    end

    // command kept until overwritten, also across programming
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_cmd <= `PPP_CMD_RESET;
        end else if (clock_en) begin
            if (load_cmd)
                mem_cmd <= data_s;
        end
    end

    // address halves chosen by the byte select
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= 16'h0000;
        end else if (clock_en) begin
            if (load_addr) begin
                if (bs_s)
                    mem_addr[15:8] <= data_s;
                else
                    mem_addr[7:0] <= data_s;
            end
        end
    end

    // data halves chosen by the byte select
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_wdata <= 16'h0000;
        end else if (clock_en) begin
            if (load_data) begin
                if (bs_s)
                    mem_wdata[15:8] <= data_s;
                else
                    mem_wdata[7:0] <= data_s;
            end
        end
    end

    // one-cycle write strobe towards the array
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_write <= 1'b0;
        end else if (clock_en) begin
            mem_write <= start_prog && (mem_cmd != `PPP_CMD_ERASE);
        end
    end

    // one-cycle erase strobe; erase uses no address or data
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_erase <= 1'b0;
        end else if (clock_en) begin
            mem_erase <= start_prog && (mem_cmd == `PPP_CMD_ERASE);
        end
    end

    // bus turned around only in programming mode, in step with the mode flag
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_oe <= 1'b0;
        end else if (clock_en) begin
            data_oe <= next_mode && !oe_n_s;
        end
    end

    // read byte picked by the select; zero while no read command is loaded
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= 8'h00;
        end else if (clock_en) begin
            if (is_read_cmd) begin
                if (bs_s)
                    data_out <= mem_rdata_hi;
                else
                    data_out <= mem_rdata_lo;
            end else begin
                data_out <= 8'h00;
            end
        end
    end
endmodule // ppp_port
`default_nettype wire

// File: ppp_defs.vh
// constants for the parallel programming port
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH
`define PPP_ACT_ADDR      2'h0
`define PPP_ACT_DATA      2'h1
`define PPP_ACT_CMD       2'h2
`define PPP_ACT_IDLE      2'h3
`define PPP_CMD_ERASE     8'h80
`define PPP_CMD_WR_FUSE   8'h40
`define PPP_CMD_WR_LOCK   8'h20
`define PPP_CMD_WR_FLASH  8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_SIG    8'h08
`define PPP_CMD_RD_FUSE   8'h04
`define PPP_CMD_RD_FLASH  8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_CMD_RESET     8'h00
`define PPP_BS_HOLD_NS    100
`define PPP_CLK_NS        25
`define PPP_BS_HOLD_CYC   ((`PPP_BS_HOLD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_PROG_CYC      64
`endif

// File: ppp_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ppp_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset_n,
    input  wire             clock_en,
    // data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (clock_en) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ppp_sync
`default_nettype wire

// File: ppp_port_assertions.sv
// checker for the programming port
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.vh"
module ppp_chk #(parameter PROG_CYC = 8) (
    // watched ports
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        prog_mode,
    input wire logic        output_drive_n,
    input wire logic        prog_done_indicator,
    input wire logic        data_oe,
    input wire logic [7:0]  data_out,
    input wire logic        mem_write,
    input wire logic        mem_erase,
    input wire logic [7:0]  mem_cmd,
    input wire logic [15:0] mem_addr
);
    logic [15:0] n_busy;
    always @(posedge clock or negedge reset_n)
        if (!reset_n) n_busy <= 16'h0000;
        else n_busy <= prog_done_indicator ? 16'h0000 : n_busy + 16'h0001;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_busy_len: assert property ($rose(prog_done_indicator) |-> n_busy == PROG_CYC)
        else $error("busy time wrong");
    chk_start_busy: assert property (mem_write || mem_erase |-> !prog_done_indicator)
        else $error("start while ready");
    chk_write_pulse: assert property (mem_write |=> !mem_write && $stable(mem_cmd))
        else $error("write pulse too long");
    chk_start_cmd: assert property (mem_write || mem_erase |-> mem_erase == (mem_cmd == `PPP_CMD_ERASE))
        else $error("start kind wrong");
    chk_busy_hold: assert property (!prog_done_indicator ##1 !prog_done_indicator
        |-> $stable(mem_cmd) && $stable(mem_addr))
        else $error("load taken while busy");
    chk_oe_mode: assert property (data_oe |-> prog_mode)
        else $error("bus driven outside mode");
    chk_oe_off: assert property ($rose(output_drive_n) |-> ##[1:4] !data_oe)
        else $error("bus not released");
    chk_idle_out: assert property ((mem_cmd[7:4] != 4'h0) [*2] |-> data_out == 8'h00)
        else $error("read data without read");
endmodule // ppp_chk
bind ppp_port ppp_chk #(.PROG_CYC(PROG_CYC)) i_chk (.clock, .reset_n, .prog_mode, .output_drive_n,
    .prog_done_indicator, .data_oe, .data_out, .mem_write, .mem_erase, .mem_cmd, .mem_addr);
`default_nettype wire

// File: ppp_prog.sv
// programmer model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module ppp_prog (
    // clock and status
    input  wire logic       clock,
    input  wire logic       prog_done_indicator,
    // pins
    output var logic        high_voltage_present = 1'b0,
    output var logic        crystal_strobe_input = 1'b0,
    output var logic        latch_action_lo = 1'b1,
    output var logic        latch_action_hi = 1'b1,
    output var logic        byte_half_select = 1'b0,
    output var logic        output_drive_n = 1'b1,
    output var logic        program_pulse_n = 1'b1,
    output var logic [7:0]  bus = 8'h00
);
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic enter;
        step(8);
        high_voltage_present <= 1'b1;
        step(8);
    endtask
    task automatic enter_bad;
        step(8);
        high_voltage_present <= 1'b1;
        step(2);
        byte_half_select <= 1'b1;
        step(8);
        high_voltage_present <= 1'b0;
        byte_half_select <= 1'b0;
        step(8);
    endtask
    task automatic load(input logic [1:0] act, input logic half, input logic [7:0] val);
        {latch_action_hi, latch_action_lo} <= act;
        byte_half_select <= half;
        bus <= val;
        step(1);
        crystal_strobe_input <= 1'b1;
        step(4);
        crystal_strobe_input <= 1'b0;
        bus <= ~val;
        step(4);
    endtask
    task automatic pulse;
        program_pulse_n <= 1'b0;
        step(4);
        program_pulse_n <= 1'b1;
        step(2);
    endtask
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        while (prog_done_indicator !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        ok = prog_done_indicator === 1'b1;
        step(1);
    endtask
    task automatic read;
        output_drive_n <= 1'b0;
        step(8);
        output_drive_n <= 1'b1;
        step(4);
    endtask
endmodule // ppp_prog
`default_nettype wire

// File: ppp_port_tb_top.sv
// testbench for the programming port
`timescale 1ns/1ps
`default_nettype none
module ppp_port_tb_top;
    logic clock = 1'b0, reset_n = 1'b0, oe_q = 1'b0, oe_qq = 1'b0, ok;
    logic high_voltage_present, crystal_strobe_input, latch_action_lo, latch_action_hi;
    logic byte_half_select, output_drive_n, program_pulse_n, prog_done_indicator;
    logic data_oe, mem_write, mem_erase, prog_mode, mode_q = 1'b0;
    logic mq[$];
    logic [7:0] bus, data_out, mem_cmd, rd_lo = 8'h00, rd_hi = 8'h00;
    logic [15:0] mem_addr, mem_wdata, a, d;
    logic [39:0] wq[$];
    logic [7:0] rq[$];
    logic [7:0] wc[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h11};
    logic [7:0] rc[4] = '{8'h08, 8'h04, 8'h02, 8'h03};
    int err_count = 0;
    int n_tests = 0;
    initial forever #12.5 clock = ~clock;
    ppp_port #(.PROG_CYC(8)) i_dut (.clock, .reset_n, .clock_en(1'b1), .high_voltage_present, .prog_mode,
        .crystal_strobe_input, .latch_action_lo, .latch_action_hi, .byte_half_select, .output_drive_n,
        .program_pulse_n, .prog_done_indicator, .data_in(data_oe ? data_out : bus), .data_out, .data_oe,
        .mem_write, .mem_erase, .mem_cmd, .mem_addr, .mem_wdata, .mem_rdata_lo(rd_lo), .mem_rdata_hi(rd_hi));
    ppp_prog i_prog (.clock, .prog_done_indicator, .high_voltage_present, .crystal_strobe_input,
        .latch_action_lo, .latch_action_hi, .byte_half_select, .output_drive_n, .program_pulse_n, .bus);
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_wr(input logic [39:0] got);
        cmp(got, wq.size() ? wq.pop_front() : 40'hX);
    endtask
    task automatic chk_rd(input logic [7:0] got);
        cmp({32'h0, got}, rq.size() ? {32'h0, rq.pop_front()} : 40'hX);
    endtask
    task automatic chk_mode(input logic got);
        cmp({39'h0, got}, mq.size() ? {39'h0, mq.pop_front()} : 40'hX);
    endtask
    task automatic test_done;
        err_count += wq.size() + rq.size() + mq.size();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic settle;
        i_prog.wait_ready(ok);
        if (!ok) begin
            err_count++;
            test_done();
        end
    endtask
    always @(negedge clock) begin
        oe_q <= data_oe;
        oe_qq <= oe_q;
        mode_q <= prog_mode;
        if (reset_n && prog_mode !== mode_q) chk_mode(prog_mode);
        if (mem_write || mem_erase) chk_wr({mem_cmd, mem_addr, mem_wdata});
        if (oe_q && !oe_qq) chk_rd(data_out);
    end
    initial begin
        void'($urandom(47));
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        i_prog.enter_bad();
        mq.push_back(1'b1);
        i_prog.enter();
        foreach (wc[i]) begin
            a = 16'($urandom);
            d = 16'($urandom) & 16'hFEFE;
            i_prog.load(2'h2, 1'b0, wc[i]);
            i_prog.load(2'h0, 1'b0, a[7:0]);
            i_prog.load(2'h0, 1'b1, a[15:8]);
            i_prog.load(2'h1, 1'b0, d[7:0]);
            i_prog.load(2'h1, 1'b1, d[15:8]);
            i_prog.load(2'h3, 1'b0, ~d[7:0]);
            wq.push_back({wc[i], a, d});
            i_prog.pulse();
            i_prog.load(2'h2, 1'b0, 8'h02);
            settle();
            a[7:0] = a[7:0] + 8'h01;
            i_prog.load(2'h0, 1'b0, a[7:0]);
            wq.push_back({wc[i], a, d});
            i_prog.pulse();
            settle();
        end
        foreach (rc[i]) for (int h = 0; h < 2; h++) begin
            rd_lo <= 8'($urandom);
            rd_hi <= 8'($urandom);
            i_prog.load(2'h2, h[0], rc[i]);
            rq.push_back(h ? rd_hi : rd_lo);
            i_prog.read();
        end
        test_done();
    end
endmodule // ppp_port_tb_top
`default_nettype wire
